/* bench/rfsc_checker.sv */
// Checker of framer B behaviour at the sync control ports.
`timescale 1ns/1ps
module rfsc_checker
  import rfsc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [RFSC_AW-1:0] addr,
  input wire logic [RFSC_DW-1:0] wdata,
  input wire logic wr_en,
  input wire logic [1:0] esf_mode,
  input wire logic [1:0] fbit_stb,
  input wire logic [1:0] fbit_err,
  input wire logic [1:0] fbit_is_fs,
  input wire logic [1:0] receive_carrier_loss,
  input wire logic [1:0] lcv_evt,
  input wire logic [1:0] exz_evt,
  input wire logic [1:0] sbit12_stb,
  input wire logic [1:0] sbit12_val,
  input wire logic [1:0] in_sync_q,
  input wire logic [1:0] oof_q,
  input wire logic [1:0] resync_start_q,
  input wire logic [1:0] lcv_inc_q,
  input wire logic [1:0] path_code_violation_counter_inc_q,
  input wire logic [1:0] mos_inc_q,
  input wire logic [1:0] yellow_q,
  input wire logic [7:0] rx_code_b_q
);
  logic [7:0] c1_q;
  logic [7:0] c2_q;
  logic err_s;
  assign err_s = fbit_stb[1] && fbit_err[1];
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      c1_q <= 8'h00;
      c2_q <= 8'h00;
    end else if (wr_en && addr == RFSC_ADDR_CTRL1_B) begin
      c1_q <= wdata;
    end else if (wr_en && addr == RFSC_ADDR_CTRL2_B) begin
      c2_q <= wdata;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  lcv_excess_a: assert property (
    exz_evt[1] && !lcv_evt[1] |=> lcv_inc_q[1] == $past(c1_q[7]))
    else $error("lcv increment wrong");
  carrier_resync_a: assert property (
    in_sync_q[1] && !oof_q[1] && receive_carrier_loss[1] && !c1_q[6]
    && !c1_q[1] |-> ##[1:2] resync_start_q[1])
    else $error("no resync on carrier loss");
  oof_cause_a: assert property (
    $rose(oof_q[1]) |-> $past(err_s) || $past(err_s, 2))
    else $error("out of frame without error");
  resync_edge_a: assert property (
    wr_en && addr == RFSC_ADDR_CTRL1_B && wdata[0] && !c1_q[0]
    |-> ##2 resync_start_q[1])
    else $error("no resync on request edge");
  idle_code_a: assert property (
    !c2_q[7] && !$past(c2_q[7]) && !$past(c2_q[7], 2)
    |-> rx_code_b_q == RFSC_IDLE_CODE)
    else $error("idle code wrong");
  yellow_sbit_a: assert property (
    !esf_mode[1] && c2_q[2] && sbit12_stb[1] && sbit12_val[1]
    |-> ##[1:2] yellow_q[1])
    else $error("yellow not detected");
  fs_report_a: assert property (
    in_sync_q[1] && !esf_mode[1] && err_s && fbit_is_fs[1]
    |=> path_code_violation_counter_inc_q[1] == $past(c2_q[1]))
    else $error("path count of signaling bit wrong");
  mos_errors_a: assert property (
    !c2_q[0] && err_s |=> mos_inc_q[1])
    else $error("multiframe count missed error");
  cover property ($rose(in_sync_q[1]));
  cover property ($rose(oof_q[1]));
  cover property (lcv_inc_q[1]);
endmodule

/* bench/rfsc_line_model.sv */
// Line receive model that sends framing bit strobes to both framers.
`timescale 1ns/1ps
module rfsc_line_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [1:0] run,
  input wire logic [1:0] err,
  input wire logic [2:0] gap,
  output logic [1:0] fbit_stb,
  output logic [1:0] fbit_err,
  output logic [1:0] fbit_is_fs
);
  logic [2:0] cnt_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 3'h0;
      fbit_stb <= 2'h0;
      fbit_err <= 2'h0;
      fbit_is_fs <= 2'h0;
    end else if (cnt_q >= gap) begin
      cnt_q <= 3'h0;
      fbit_stb <= run;
      fbit_err <= err;
      fbit_is_fs <= ~fbit_is_fs;
    end else begin
      cnt_q <= cnt_q + 3'h1;
      fbit_stb <= 2'h0;
      fbit_err <= ~fbit_err;
    end
  end
endmodule

/* bench/rfsc_top_bench.sv */
// Self-checking bench for the receive framer sync control block.
`timescale 1ns/1ps
module rfsc_top_bench
  import rfsc_pkg::*;
;
  logic ref_clk, nrst, wr_en, rd_en;
  logic [2:0] gap;
  logic [7:0] addr, wdata, rdata_q, rx_code_a_q, rx_code_b_q;
  logic [1:0] esf_mode, fbit_stb, fbit_err, fbit_is_fs, crc_ok, crc_err;
  logic [1:0] receive_carrier_loss, lcv_evt, exz_evt, mf_stb, chan_stb;
  logic [1:0] chan_bit2, frame_end_stb, sbit12_stb, sbit12_val, code_stb;
  logic [1:0] in_sync_q, oof_q, resync_start_q, lcv_inc_q, mos_inc_q;
  logic [1:0] path_code_violation_counter_inc_q, yellow_q, run, err;
  int n_fail, comparisons, k, n_rs [2];
  logic [7:0] c1_addr [2] = '{RFSC_ADDR_CTRL1_A, RFSC_ADDR_CTRL1_B};
  logic [7:0] c2_addr [2] = '{RFSC_ADDR_CTRL2_A, RFSC_ADDR_CTRL2_B};
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    n_rs[0] += resync_start_q[0];
    n_rs[1] += resync_start_q[1];
  end
  rfsc_top i_rfsc_top (.ref_clk, .nrst, .addr, .wdata, .wr_en, .rd_en,
    .rdata_q, .esf_mode, .fbit_stb, .fbit_err, .fbit_is_fs, .crc_ok,
    .crc_err, .receive_carrier_loss, .lcv_evt, .exz_evt, .mf_stb, .chan_stb,
    .chan_bit2, .frame_end_stb, .sbit12_stb, .sbit12_val, .code_stb,
    .in_sync_q, .oof_q, .resync_start_q, .lcv_inc_q,
    .path_code_violation_counter_inc_q, .mos_inc_q, .yellow_q,
    .rx_code_a_q, .rx_code_b_q);
  rfsc_line_model i_rfsc_line_model (.ref_clk, .nrst, .run, .err, .gap,
    .fbit_stb, .fbit_err, .fbit_is_fs);
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk("register", e, rdata_q);
  endtask
  task automatic sync_b(input logic [7:0] c1, input int want);
    int n;
    n = 0;
    wr(RFSC_ADDR_CTRL1_B, c1);
    wr(RFSC_ADDR_CTRL1_B, c1 | 8'h01);
    repeat (3) @(posedge ref_clk);
    run <= 2'b10;
    for (int i = 0; i < 400 && in_sync_q[1] !== 1'b1; i++) begin
      @(posedge ref_clk);
      n += fbit_stb[1];
      #1;
    end
    @(posedge ref_clk);
    run <= 2'b00;
    chk("qualify bits", 8'(want), 8'(n));
    if (in_sync_q[1] !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
  endtask
  task automatic err_run();
    @(posedge ref_clk);
    run <= 2'b10;
    err <= 2'b10;
    repeat (60) @(posedge ref_clk);
    run <= 2'b00;
    err <= 2'b00;
    settle(3);
  endtask
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    {wr_en, rd_en, addr, wdata, gap} = '0;
    {esf_mode, crc_ok, crc_err, receive_carrier_loss, lcv_evt} = '0;
    {exz_evt, mf_stb, chan_stb, chan_bit2, frame_end_stb} = '0;
    {sbit12_stb, sbit12_val, code_stb, run, err} = '0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      rd_chk(c1_addr[i], RFSC_CTRL_RST);
      rd_chk(c2_addr[i], RFSC_CTRL_RST);
      wr(c1_addr[i], 8'hA5);
      wr(c2_addr[i], 8'h5A);
      rd_chk(c1_addr[i], 8'hA5);
      rd_chk(c2_addr[i], 8'h5A);
      wr(c1_addr[i], 8'h00);
      wr(c2_addr[i], 8'h00);
    end
    rd_chk(8'h2D, RFSC_RD_UNMAPPED);
    $display("test registers done");
    for (int i = 0; i < 2; i++) begin
      k = n_rs[i];
      wr(c1_addr[i], 8'h01);
      settle(3);
      chk("resync", 8'(k + 1), 8'(n_rs[i]));
      wr(c1_addr[i], 8'h01);
      settle(3);
      chk("no resync", 8'(k + 1), 8'(n_rs[i]));
    end
    $display("test resync done");
    gap <= 3'h2;
    sync_b(8'h08, 10);
    k = n_rs[1];
    receive_carrier_loss <= 2'b10;
    @(posedge ref_clk);
    receive_carrier_loss <= 2'b00;
    settle(3);
    chk("carrier resync", 8'(k + 1), 8'(n_rs[1]));
    gap <= 3'h5;
    sync_b(8'h0C, 24);
    k = n_rs[1];
    err_run();
    chk("auto resync", 8'(k + 1), 8'(n_rs[1]));
    sync_b(8'h0A, 10);
    k = n_rs[1];
    wr(RFSC_ADDR_CTRL2_B, 8'h02);
    err_run();
    chk("held", 8'(k), 8'(n_rs[1]));
    chk("oof", 8'h01, oof_q[1]);
    esf_mode <= 2'b10;
    sync_b(8'h00, 10);
    wr(RFSC_ADDR_CTRL1_B, 8'h08);
    wr(RFSC_ADDR_CTRL1_B, 8'h09);
    run <= 2'b10;
    settle(90);
    chk("crc wait", 8'h00, in_sync_q[1]);
    crc_ok <= 2'b10;
    @(posedge ref_clk);
    crc_ok <= 2'b00;
    settle(2);
    chk("crc sync", 8'h01, in_sync_q[1]);
    run <= 2'b00;
    esf_mode <= 2'b00;
    $display("test sync done");
    wr(RFSC_ADDR_CTRL2_B, 8'h80);
    settle(2);
    for (int i = 0; i < 9; i++) begin
      chk("mw code", RFSC_MW_SEQ[i % 8], rx_code_b_q);
      code_stb <= 2'b10;
      @(posedge ref_clk);
      code_stb <= 2'b00;
      settle(1);
    end
    wr(RFSC_ADDR_CTRL2_B, 8'h00);
    settle(3);
    chk("idle code", RFSC_IDLE_CODE, rx_code_b_q);
    chk("idle code a", RFSC_IDLE_CODE, rx_code_a_q);
    for (int v = 0; v < 2; v++) begin
      wr(RFSC_ADDR_CTRL1_B, v ? 8'h80 : 8'h00);
      wr(RFSC_ADDR_CTRL2_B, v ? 8'h04 : 8'h00);
      esf_mode <= v ? 2'b00 : 2'b10;
      {exz_evt, mf_stb, frame_end_stb, sbit12_stb, sbit12_val} <= 10'h3FF;
      @(posedge ref_clk);
      {exz_evt, mf_stb, frame_end_stb, sbit12_stb, sbit12_val} <= 10'h000;
      #1;
      chk("lcv inc", 8'(v), lcv_inc_q[1]);
      settle(2);
      chk("yellow", 8'(v), yellow_q[1]);
    end
    $display("test counters done");
    wrap_up();
  end
endmodule
bind rfsc_top rfsc_checker i_rfsc_checker (.ref_clk, .nrst, .addr, .wdata,
  .wr_en, .esf_mode, .fbit_stb, .fbit_err, .fbit_is_fs,
  .receive_carrier_loss, .lcv_evt, .exz_evt, .sbit12_stb, .sbit12_val,
  .in_sync_q, .oof_q, .resync_start_q, .lcv_inc_q,
  .path_code_violation_counter_inc_q, .mos_inc_q, .yellow_q,
  .rx_code_b_q);

/* core/rfsc_code_gen.sv */
// Receive code generator: idle byte or the milliwatt byte sequence.
`timescale 1ns/1ps
module rfsc_code_gen
  import rfsc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic mw_sel,
  input wire logic byte_stb,
  output logic [7:0] code_q
);

  logic [2:0] idx_q;

  // The sequence index restarts whenever the idle code is chosen.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      idx_q <= 3'h0;
    end else if (!mw_sel) begin
      idx_q <= 3'h0;
    end else if (byte_stb) begin
      idx_q <= idx_q + 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      code_q <= RFSC_IDLE_CODE;
    end else if (mw_sel) begin
      code_q <= RFSC_MW_SEQ[idx_q];
    end else begin
      code_q <= RFSC_IDLE_CODE;
    end
  end

endmodule

/* core/rfsc_pkg.sv */
// Constants shared by the receive framer sync control block.
package rfsc_pkg;

  localparam int RFSC_AW = 8;
  localparam int RFSC_DW = 8;

  localparam logic [7:0] RFSC_ADDR_CTRL1_A = 8'h2B;
  localparam logic [7:0] RFSC_ADDR_CTRL2_A = 8'h2C;
  localparam logic [7:0] RFSC_ADDR_CTRL1_B = 8'hCB;
  localparam logic [7:0] RFSC_ADDR_CTRL2_B = 8'hCC;
  localparam logic [7:0] RFSC_CTRL_RST = 8'h00;
  localparam logic [7:0] RFSC_RD_UNMAPPED = 8'h00;

  localparam int RFSC_C1_LCV_SEL = 7;
  localparam int RFSC_C1_ARC = 6;
  localparam int RFSC_C1_FRAME_LOSS_SELECT_FIRST = 5;
  localparam int RFSC_C1_FRAME_LOSS_SELECT_SECOND = 4;
  localparam int RFSC_C1_CRIT = 3;
  localparam int RFSC_C1_QTIME = 2;
  localparam int RFSC_C1_NOAUTO = 1;
  localparam int RFSC_C1_RESYNC = 0;

  localparam int RFSC_C2_CODE_SEL = 7;
  localparam int RFSC_C2_YEL_METH = 2;
  localparam int RFSC_C2_FS_REPORT = 1;
  localparam int RFSC_C2_MF_FUNC = 0;

  localparam logic [4:0] RFSC_QUAL_SHORT = 5'd10;
  localparam logic [4:0] RFSC_QUAL_LONG = 5'd24;

  localparam logic [2:0] RFSC_WIN_4 = 3'd4;
  localparam logic [2:0] RFSC_WIN_5 = 3'd5;
  localparam logic [2:0] RFSC_WIN_6 = 3'd6;
  localparam logic [2:0] RFSC_OOF_ERRS = 3'd2;

  localparam logic [7:0] RFSC_IDLE_CODE = 8'h7F;
  localparam logic [7:0] RFSC_MW_SEQ [8] = '{8'h1E, 8'h0B, 8'h0B, 8'h1E,
                                           8'h9E, 8'h8B, 8'h8B, 8'h9E};

  typedef enum logic [1:0] {
    RFSC_SEARCH_FT,
    RFSC_SEARCH_FS,
    RFSC_VERIFY_CRC,
    RFSC_IN_SYNC
  } rfsc_sync_t;

endpackage

/* core/rfsc_top.sv */
// Receive framer sync control for two framers behind the control port.
`timescale 1ns/1ps
module rfsc_top
  import rfsc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [RFSC_AW-1:0] addr,
  input wire logic [RFSC_DW-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [RFSC_DW-1:0] rdata_q,
  input wire logic [1:0] esf_mode,
  input wire logic [1:0] fbit_stb,
  input wire logic [1:0] fbit_err,
  input wire logic [1:0] fbit_is_fs,
  input wire logic [1:0] crc_ok,
  input wire logic [1:0] crc_err,
  input wire logic [1:0] receive_carrier_loss,
  input wire logic [1:0] lcv_evt,
  input wire logic [1:0] exz_evt,
  input wire logic [1:0] mf_stb,
  input wire logic [1:0] chan_stb,
  input wire logic [1:0] chan_bit2,
  input wire logic [1:0] frame_end_stb,
  input wire logic [1:0] sbit12_stb,
  input wire logic [1:0] sbit12_val,
  input wire logic [1:0] code_stb,
  output logic [1:0] in_sync_q,
  output logic [1:0] oof_q,
  output logic [1:0] resync_start_q,
  output logic [1:0] lcv_inc_q,
  output logic [1:0] path_code_violation_counter_inc_q,
  output logic [1:0] mos_inc_q,
  output logic [1:0] yellow_q,
  output logic [7:0] rx_code_a_q,
  output logic [7:0] rx_code_b_q
);

  logic [7:0] ctrl1_q [2];
  logic [7:0] ctrl2_q [2];
  logic [1:0] resync_prev_q;
  logic [7:0] code_q [2];

  // Control registers; reset loads RFSC_CTRL_RST until software programs them.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl1_q[0] <= RFSC_CTRL_RST;
      ctrl2_q[0] <= RFSC_CTRL_RST;
      ctrl1_q[1] <= RFSC_CTRL_RST;
      ctrl2_q[1] <= RFSC_CTRL_RST;
    end else if (wr_en) begin
      unique case (addr)
        RFSC_ADDR_CTRL1_A: ctrl1_q[0] <= wdata;
        RFSC_ADDR_CTRL2_A: ctrl2_q[0] <= wdata;
        RFSC_ADDR_CTRL1_B: ctrl1_q[1] <= wdata;
        RFSC_ADDR_CTRL2_B: ctrl2_q[1] <= wdata;
        default: ;
      endcase
    end
  end

  // Read data is registered; unmapped addresses read zero.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= RFSC_RD_UNMAPPED;
    end else if (rd_en) begin
      unique case (addr)
        RFSC_ADDR_CTRL1_A: rdata_q <= ctrl1_q[0];
        RFSC_ADDR_CTRL2_A: rdata_q <= ctrl2_q[0];
        RFSC_ADDR_CTRL1_B: rdata_q <= ctrl1_q[1];
        RFSC_ADDR_CTRL2_B: rdata_q <= ctrl2_q[1];
        default: rdata_q <= RFSC_RD_UNMAPPED;
      endcase
    end
  end

  // Previous value of each resync request bit for edge detection.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      resync_prev_q <= 2'b00;
    end else begin
      resync_prev_q[0] <= ctrl1_q[0][RFSC_C1_RESYNC];
      resync_prev_q[1] <= ctrl1_q[1][RFSC_C1_RESYNC];
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_framer
    rfsc_sync_t state_q;
    logic [4:0] qual_cnt_q;
    logic [5:0] err_hist_q;
    logic [5:0] hist_d;
    logic [2:0] win;
    logic [2:0] err_cnt;
    logic [4:0] qual_target;
    logic manual_req;
    logic auto_req;
    logic start;
    logic oof_evt;
    logic counts_bit;
    logic bit2_zero_q;
    logic [7:0] c1;
    logic [7:0] c2;

    assign c1 = ctrl1_q[g];
    assign c2 = ctrl2_q[g];

    assign manual_req = c1[RFSC_C1_RESYNC] && !resync_prev_q[g];

    always_comb begin
      if (c1[RFSC_C1_FRAME_LOSS_SELECT_SECOND]) begin
        win = RFSC_WIN_6;
      end else if (c1[RFSC_C1_FRAME_LOSS_SELECT_FIRST]) begin
        win = RFSC_WIN_5;
      end else begin
        win = RFSC_WIN_4;
      end
    end

    // Count errored framing bits among the newest ones in the window.
    always_comb begin
      hist_d = {err_hist_q[4:0], fbit_err[g]};
      err_cnt = 3'd0;
      for (int i = 0; i < 6; i++) begin
        if (3'(i) < win && hist_d[i]) begin
          err_cnt = err_cnt + 3'd1;
        end
      end
    end

    assign oof_evt = (state_q == RFSC_IN_SYNC) && fbit_stb[g] &&
                     (err_cnt >= RFSC_OOF_ERRS);

    // Carrier loss also qualifies only while the ARC bit is zero.
    assign auto_req = !c1[RFSC_C1_NOAUTO] &&
                      (state_q == RFSC_IN_SYNC) &&
                      (oof_evt || (!c1[RFSC_C1_ARC] &&
                                   receive_carrier_loss[g]));

    assign start = manual_req || auto_req;

    assign qual_target = c1[RFSC_C1_QTIME] ? RFSC_QUAL_LONG :
                         RFSC_QUAL_SHORT;

    // Which framing bits the current search stage qualifies on.
    always_comb begin
      if (esf_mode[g] || c1[RFSC_C1_CRIT]) begin
        counts_bit = 1'b1;
      end else if (state_q == RFSC_SEARCH_FT) begin
        counts_bit = !fbit_is_fs[g];
      end else begin
        counts_bit = fbit_is_fs[g];
      end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        err_hist_q <= 6'h00;
      end else if (start) begin
        err_hist_q <= 6'h00;
      end else if (fbit_stb[g] && state_q == RFSC_IN_SYNC) begin
        err_hist_q <= hist_d;
      end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        state_q <= RFSC_SEARCH_FT;
        qual_cnt_q <= 5'd0;
      end else if (start) begin
        state_q <= RFSC_SEARCH_FT;
        qual_cnt_q <= 5'd0;
      end else begin
        unique case (state_q)
          RFSC_SEARCH_FT,
          RFSC_SEARCH_FS: begin
            if (fbit_stb[g] && counts_bit) begin
              if (fbit_err[g]) begin
                qual_cnt_q <= 5'd0;
              end else if (qual_cnt_q + 5'd1 >= qual_target) begin
                qual_cnt_q <= 5'd0;
                if (esf_mode[g]) begin
                  state_q <= c1[RFSC_C1_CRIT] ? RFSC_VERIFY_CRC :
                             RFSC_IN_SYNC;
                end else if (c1[RFSC_C1_CRIT] ||
                             state_q == RFSC_SEARCH_FS) begin
                  state_q <= RFSC_IN_SYNC;
                end else begin
                  state_q <= RFSC_SEARCH_FS;
                end
              end else begin
                qual_cnt_q <= qual_cnt_q + 5'd1;
              end
            end
          end
          RFSC_VERIFY_CRC: begin
            if (crc_err[g]) begin
              state_q <= RFSC_SEARCH_FT;
            end else if (crc_ok[g]) begin
              state_q <= RFSC_IN_SYNC;
            end
          end
          RFSC_IN_SYNC: ;
        endcase
      end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        oof_q[g] <= 1'b0;
        in_sync_q[g] <= 1'b0;
        resync_start_q[g] <= 1'b0;
      end else begin
        oof_q[g] <= oof_evt || (oof_q[g] && !start);
        in_sync_q[g] <= (state_q == RFSC_IN_SYNC) && !start;
        resync_start_q[g] <= start;
      end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        lcv_inc_q[g] <= 1'b0;
        path_code_violation_counter_inc_q[g] <= 1'b0;
        mos_inc_q[g] <= 1'b0;
      end else begin
        lcv_inc_q[g] <= lcv_evt[g] ||
                        (c1[RFSC_C1_LCV_SEL] && exz_evt[g]);
        path_code_violation_counter_inc_q[g] <=
          fbit_stb[g] && fbit_err[g] && (state_q == RFSC_IN_SYNC) &&
          (!fbit_is_fs[g] || c2[RFSC_C2_FS_REPORT]);
        if (c2[RFSC_C2_MF_FUNC]) begin
          mos_inc_q[g] <= mf_stb[g] && !in_sync_q[g];
        end else begin
          mos_inc_q[g] <= fbit_stb[g] && fbit_err[g];
        end
      end
    end

    // Bit-2 tracker: stays set while every channel's bit 2 is zero.
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        bit2_zero_q <= 1'b1;
      end else if (frame_end_stb[g]) begin
        bit2_zero_q <= 1'b1;
      end else if (chan_stb[g] && chan_bit2[g]) begin
        bit2_zero_q <= 1'b0;
      end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        yellow_q[g] <= 1'b0;
      end else if (esf_mode[g]) begin
        yellow_q[g] <= 1'b0;
      end else if (c2[RFSC_C2_YEL_METH]) begin
        if (sbit12_stb[g]) begin
          yellow_q[g] <= sbit12_val[g];
        end
      end else if (frame_end_stb[g]) begin
        yellow_q[g] <= bit2_zero_q && !(chan_stb[g] && chan_bit2[g]);
      end
    end

    rfsc_code_gen u_code (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .mw_sel(c2[RFSC_C2_CODE_SEL]),
      .byte_stb(code_stb[g]),
      .code_q(code_q[g])
    );
  end

  assign rx_code_a_q = code_q[0];
  assign rx_code_b_q = code_q[1];

endmodule
